// >>> pkg/stepper_pkg.sv
// Constants and types shared by the stepper chopper and protection block
package stepper_pkg;
  // Clock and blanking times
  localparam int CLK_PERIOD_NS = 25;
  localparam int BLANK_NS_0    = 600;
  localparam int BLANK_NS_1    = 900;
  localparam int BLANK_NS_2    = 1200;
  localparam int BLANK_NS_3    = 1500;
  localparam int BLANK_W       = 7;
  localparam logic [BLANK_W-1:0] BLANK_CYC_0 =
    BLANK_W'((BLANK_NS_0 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [BLANK_W-1:0] BLANK_CYC_1 =
    BLANK_W'((BLANK_NS_1 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [BLANK_W-1:0] BLANK_CYC_2 =
    BLANK_W'((BLANK_NS_2 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [BLANK_W-1:0] BLANK_CYC_3 =
    BLANK_W'((BLANK_NS_3 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  // Longest fast decay portion of a mixed decay cycle
  localparam int FAST_MAX_NS  = 10000;
  localparam int FAST_W       = 10;
  localparam int FAST_MAX_CYC = FAST_MAX_NS / CLK_PERIOD_NS;
  // Overcurrent counters
  localparam int OC_CNT_W = 2;
  localparam int OC_WIN_W = 7;
  localparam logic [OC_CNT_W-1:0] OC_TRIP_COUNT   = 2'h3;
  localparam logic [OC_WIN_W-1:0] OC_LOCK_CYCLES  = 7'h3f;
  localparam logic [OC_WIN_W-1:0] OC_QUIET_CYCLES = 7'h3f;
  // Command word fields
  localparam int CMD_W = 12;
  localparam int CMD_MDA = 11;
  localparam int CMD_CA_MSB = 10;
  localparam int CMD_CA_LSB = 7;
  localparam int CMD_PHA = 6;
  localparam int CMD_MDB = 5;
  localparam int CMD_CB_MSB = 4;
  localparam int CMD_CB_LSB = 1;
  localparam int CMD_PHB = 0;
  localparam logic [CMD_W-1:0] CMD_RESET = 12'h000;
  localparam logic [3:0] CODE_OFF = 4'h0;
  // Status word fields
  localparam int LOAD_LEVEL_MSB = 11;
  localparam int LOAD_LEVEL_LSB = 9;
  localparam int ST_ONE = 8;
  localparam int ST_OT = 7;
  localparam int ST_HIGHSIDE_OVERCURRENT_FLAG = 4;
  localparam int ST_OCB = 1;
  localparam int ST_OCA = 0;
  localparam int LOAD_W = 3;
  localparam logic [CMD_W-1:0] STATUS_RESET = 12'h100;
  // Chopper states
  typedef enum logic [2:0] {
    CH_IDLE = 3'b000,
    CH_ON   = 3'b001,
    CH_FAST = 3'b010,
    CH_SLOW = 3'b011,
    CH_OFF  = 3'b100
  } chop_state_t;
  // Gate patterns {high1, high2, low1, low2}
  localparam logic [3:0] GATE_OFF     = 4'h0;
  localparam logic [3:0] GATE_SLOW    = 4'h3;
  localparam logic [3:0] GATE_ON_P0   = 4'h9;
  localparam logic [3:0] GATE_ON_P1   = 4'h6;
  localparam logic [3:0] GATE_FAST_P0 = 4'h2;
  localparam logic [3:0] GATE_FAST_P1 = 4'h1;
endpackage

// >>> pkg/bridge_if.sv
// Signals between the protection core and one bridge chopper
`timescale 1ns/1ps
`default_nettype none
interface bridge_if;
  import stepper_pkg::*;
  logic               cycle_start;
  logic               polarity;
  logic               mixed;
  logic               code_zero;
  logic               kill;
  logic               lowside_comp;
  logic               sense_comp;
  logic [BLANK_W-1:0] blank_cyc;
  chop_state_t        state;
  logic [3:0]         gates;
  logic               blank_active;
  logic               driving;
  logic               oc_event;
  modport ctrl (output cycle_start, polarity, mixed, code_zero, kill,
                output lowside_comp, sense_comp, blank_cyc,
                input state, gates, blank_active, driving, oc_event);
  modport chop (input cycle_start, polarity, mixed, code_zero, kill,
                input lowside_comp, sense_comp, blank_cyc,
                output state, gates, blank_active, driving, oc_event);
endinterface
`default_nettype wire

// >>> hdl/chopper_bridge.sv
// Fixed frequency chopper with blanking and decay patterns for one bridge
`timescale 1ns/1ps
`default_nettype none
module chopper_bridge #(
  parameter int FAST_MAX = stepper_pkg::FAST_MAX_CYC
) (
  input wire logic ref_clk,
  input wire logic srst_n,
  bridge_if.chop   br
);
  import stepper_pkg::*;
  if (FAST_MAX < 1 || FAST_MAX >= (1 << FAST_W)) begin : g_bad_fast
    $error("FAST_MAX out of range");
  end
  chop_state_t        state_reg, state_next;
  logic [BLANK_W-1:0] blank_reg, blank_next;
  logic [FAST_W-1:0]  on_reg, fast_reg;
  logic               pol_reg;
  wire logic [FAST_W-1:0] fast_max = FAST_W'(FAST_MAX);
  wire logic pol_chg = br.polarity != pol_reg;
  wire logic restart = br.cycle_start | pol_chg; // RULE14
  wire logic active  = state_reg == CH_ON || state_reg == CH_FAST ||
                       state_reg == CH_SLOW;
  wire logic ls_trip = active & br.lowside_comp & ~br.blank_active; // RULE7
  wire logic cur_trip = active & br.sense_comp & ~br.blank_active;
  // Fast decay shrinks as the on time grows
  wire logic [FAST_W-1:0] fast_len =
    (on_reg >= fast_max) ? '0 : fast_max - on_reg; // RULE13
  assign br.blank_active = blank_reg != '0;
  assign br.driving  = active;
  assign br.oc_event = ls_trip; // RULE2
  assign br.state    = state_reg;
  // Gate decode
  assign br.gates =
    (state_reg == CH_ON) ? (pol_reg ? GATE_ON_P1 : GATE_ON_P0) :
    (state_reg == CH_FAST) ? (pol_reg ? GATE_FAST_P1 : GATE_FAST_P0) : // RULE15
    (state_reg == CH_SLOW || state_reg == CH_IDLE) ? GATE_SLOW : // RULE16
    GATE_OFF;
  // Next state
  always_comb begin
    state_next = state_reg;
    blank_next = br.blank_active ? blank_reg - 1'b1 : '0;
    if (br.code_zero) begin
      state_next = CH_IDLE; // RULE24
    end else if (br.kill | ls_trip) begin
      state_next = CH_OFF; // RULE2
    end else if (restart) begin
      state_next = CH_ON;
      blank_next = br.blank_cyc; // RULE17
    end else begin
      case (state_reg)
        CH_ON: begin
          if (cur_trip) begin
            state_next = (br.mixed && fast_len != '0) ? CH_FAST : CH_SLOW;
            blank_next = br.blank_cyc;
          end
        end
        CH_FAST: begin
          if (fast_reg <= FAST_W'(1)) state_next = CH_SLOW;
        end
        default: ;
      endcase
    end
  end
  // State registers
  always_ff @(posedge ref_clk) begin
    if (!srst_n) begin
      state_reg <= CH_IDLE;
      blank_reg <= '0;
      on_reg    <= '0;
      fast_reg  <= '0;
      pol_reg   <= 1'b0;
    end else begin
      state_reg <= state_next;
      blank_reg <= blank_next;
      pol_reg   <= br.polarity;
      on_reg    <= restart ? '0 : on_reg + FAST_W'(state_reg == CH_ON &&
                                                  on_reg != fast_max);
      fast_reg  <= (state_next == CH_FAST && state_reg != CH_FAST) ?
                   fast_len : fast_reg - FAST_W'(fast_reg != '0);
    end
  end
endmodule
`default_nettype wire

// >>> hdl/oc_counter.sv
// Overcurrent error counter with lockout and sticky flag
`timescale 1ns/1ps
`default_nettype none
module oc_counter (
  input  wire logic ref_clk,
  input  wire logic srst_n,
  input  wire logic tick,
  input  wire logic oc_event,
  input  wire logic flag_clear,
  output logic      flag,
  output logic      lockout
);
  import stepper_pkg::*;
  logic [OC_CNT_W-1:0] cnt_reg;
  logic [OC_WIN_W-1:0] quiet_reg, lock_reg;
  logic                flag_reg;
  wire logic under = cnt_reg < OC_TRIP_COUNT;
  wire logic trip  = oc_event & (OC_CNT_W'(cnt_reg + 1'b1) == OC_TRIP_COUNT);
  wire logic lock_end = tick & (lock_reg == OC_WIN_W'(1));
  assign flag    = flag_reg;
  assign lockout = lock_reg != '0;
  // Counting, lockout and flag; a trip wins over a clear
  always_ff @(posedge ref_clk) begin
    if (!srst_n) begin
      cnt_reg <= '0; quiet_reg <= '0; lock_reg <= '0; flag_reg <= 1'b0;
    end else if (trip && under) begin
      cnt_reg <= OC_TRIP_COUNT; lock_reg <= OC_LOCK_CYCLES; // RULE3
      flag_reg <= 1'b1; quiet_reg <= '0;
    end else if (flag_clear | lock_end) begin
      cnt_reg <= '0; lock_reg <= '0; quiet_reg <= '0; // RULE4 RULE26
      flag_reg <= flag_reg & ~flag_clear;
    end else if (oc_event && under) begin
      cnt_reg <= cnt_reg + 1'b1; quiet_reg <= '0;
    end else if (tick) begin
      if (quiet_reg == OC_QUIET_CYCLES) cnt_reg <= '0; // RULE5
      else quiet_reg <= quiet_reg + 1'b1;
      lock_reg <= lock_reg - OC_WIN_W'(lockout);
    end
  end
endmodule
`default_nettype wire

// >>> hdl/stepper_chopper_protection.sv
// Stepper chopper, overcurrent protection and status word
//
// Contract
// (RULE1) Latch load level per fullstep, mixed off
// (RULE2) Low-side trip ends cycle, bridge off
// (RULE3) Third error: 63 cycle lockout, flag
// (RULE4) Clearing flag ends lockout early
// (RULE5) 64 quiet cycles clear error counter
// (RULE6) Three counters: A, B, high side
// (RULE7) Ignore low-side trip during blanking
// (RULE8) High-side trip turns both bridges off
// (RULE9) Disable or zero frame clears flags
// (RULE10) Overtemperature turns all transistors off
// (RULE11) Disabled: all off, cleared, shutdown
// (RULE12) Bridges chopped 180 degrees apart
// (RULE13) Longer on time shortens fast decay
// (RULE14) Polarity change restarts bridge cycle
// (RULE15) Fast decay: opposite lower transistor only
// (RULE16) Slow decay: both lower transistors on
// (RULE17) Blank time from two strap pins
// (RULE18) Host reads load each fullstep, stops
// (RULE19) Host calibrates moving load, threshold
// (RULE20) Host keeps mixed off before zero cross
// (RULE21) Host uses mixed decay on falling half
// (RULE22) Load level in status bits 11..9
// (RULE23) Overcurrent flags in status bits 4,1,0
// (RULE24) Code zero holds bridge in slow decay
// (RULE25) Mixed decay enables from bits 11, 5
// (RULE26) Lockout counts PWM cycles, clears counter
`timescale 1ns/1ps
`default_nettype none
module stepper_chopper_protection #(
  parameter int FAST_MAX = stepper_pkg::FAST_MAX_CYC
) (
  input  wire logic                          ref_clk,
  input  wire logic                          rst_n,
  input  wire logic                          disable_pin,
  input  wire logic                          osc_in,
  input  wire logic [stepper_pkg::CMD_W-1:0] cmd_word,
  input  wire logic                          cmd_valid,
  input  wire logic                          blank_select_low,
  input  wire logic                          blank_select_high,
  input  wire logic                          lowside_comp_a,
  input  wire logic                          lowside_comp_b,
  input  wire logic                          sense_comp_a,
  input  wire logic                          sense_comp_b,
  input  wire logic                          highside_comp,
  input  wire logic                          overtemp,
  input  wire logic                          prewarn,
  input  wire logic                          undervolt,
  input  wire logic                          open_load_a,
  input  wire logic                          open_load_b,
  input  wire logic [stepper_pkg::LOAD_W-1:0] load_sample,
  output logic [3:0]                         gates_a,
  output logic [3:0]                         gates_b,
  output logic                               shutdown,
  output logic [stepper_pkg::CMD_W-1:0]      status_word
);
  import stepper_pkg::*;

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  bridge_if br_a ();
  bridge_if br_b ();
  logic [CMD_W-1:0]  cmd_reg;
  logic [CMD_W-1:0]  status_reg;
  logic [LOAD_W-1:0] load_reg;
  logic [3:0]        gates_a_reg, gates_b_reg;
  logic              osc_reg;
  logic              shutdown_reg;
  logic [1:0]        blank_sel_reg;
  logic              flag_a, flag_b, flag_hs;
  logic              lock_a, lock_b, lock_hs;
  logic [OC_WIN_W-1:0] lock_ticks;

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  // Disable acts as a reset of every register field except shutdown_reg
  wire logic srst_n = rst_n & ~disable_pin; // RULE11
  // Oscillator edges start the two bridges' cycles
  wire logic cyc_a = osc_in & ~osc_reg; // RULE12
  wire logic cyc_b = ~osc_in & osc_reg; // RULE12
  // Command fields
  wire logic mixed_decay_on_a = cmd_reg[CMD_MDA]; // RULE25
  wire logic mixed_decay_on_b = cmd_reg[CMD_MDB]; // RULE25
  wire logic code_zero_a = cmd_reg[CMD_CA_MSB:CMD_CA_LSB] == CODE_OFF;
  wire logic code_zero_b = cmd_reg[CMD_CB_MSB:CMD_CB_LSB] == CODE_OFF;
  // Both codes zero in a new frame clears the flags
  wire logic flag_clear = cmd_valid &
    (cmd_word[CMD_CA_MSB:CMD_CA_LSB] == CODE_OFF) &
    (cmd_word[CMD_CB_MSB:CMD_CB_LSB] == CODE_OFF); // RULE9
  // Fullstep: a polarity change with mixed decay off
  wire logic step_a = cmd_valid & (cmd_word[CMD_PHA] != cmd_reg[CMD_PHA]) &
                      ~cmd_word[CMD_MDA];
  wire logic step_b = cmd_valid & (cmd_word[CMD_PHB] != cmd_reg[CMD_PHB]) &
                      ~cmd_word[CMD_MDB];
  // High-side trip outside the ORed blanking windows
  wire logic hs_trip = highside_comp &
    ~(br_a.blank_active | br_b.blank_active) &
    (br_a.driving | br_b.driving); // RULE8
  wire logic hs_kill = hs_trip | lock_hs; // RULE8
  // Blank length from the strap pins
  wire logic [BLANK_W-1:0] blank_cyc =
    (blank_sel_reg == 2'h0) ? BLANK_CYC_0 :
    (blank_sel_reg == 2'h1) ? BLANK_CYC_1 :
    (blank_sel_reg == 2'h2) ? BLANK_CYC_2 : BLANK_CYC_3; // RULE17

  // ----------------------------------------------------------------
  // Bridge connections
  // ----------------------------------------------------------------
  // Bridge A side
  assign br_a.cycle_start  = cyc_a;
  assign br_a.polarity     = cmd_reg[CMD_PHA];
  assign br_a.mixed        = mixed_decay_on_a;
  assign br_a.code_zero    = code_zero_a; // RULE24
  assign br_a.kill         = hs_kill | lock_a; // RULE3
  assign br_a.lowside_comp = lowside_comp_a;
  assign br_a.sense_comp   = sense_comp_a;
  assign br_a.blank_cyc    = blank_cyc;
  // Bridge B side
  assign br_b.cycle_start  = cyc_b;
  assign br_b.polarity     = cmd_reg[CMD_PHB];
  assign br_b.mixed        = mixed_decay_on_b;
  assign br_b.code_zero    = code_zero_b; // RULE24
  assign br_b.kill         = hs_kill | lock_b; // RULE3
  assign br_b.lowside_comp = lowside_comp_b;
  assign br_b.sense_comp   = sense_comp_b;
  assign br_b.blank_cyc    = blank_cyc;

  // ----------------------------------------------------------------
  // Choppers and error counters
  // ----------------------------------------------------------------
  chopper_bridge #(.FAST_MAX(FAST_MAX)) u_chop_a (
    .ref_clk (ref_clk),
    .srst_n  (srst_n),
    .br      (br_a.chop)
  );
  chopper_bridge #(.FAST_MAX(FAST_MAX)) u_chop_b (
    .ref_clk (ref_clk),
    .srst_n  (srst_n),
    .br      (br_b.chop)
  );
  // One counter per low side and one for the high side
  oc_counter u_oc_a ( // RULE6
    .ref_clk    (ref_clk),
    .srst_n     (srst_n),
    .tick       (cyc_a), // RULE26
    .oc_event   (br_a.oc_event),
    .flag_clear (flag_clear),
    .flag       (flag_a),
    .lockout    (lock_a)
  );
  oc_counter u_oc_b ( // RULE6
    .ref_clk    (ref_clk),
    .srst_n     (srst_n),
    .tick       (cyc_b), // RULE26
    .oc_event   (br_b.oc_event),
    .flag_clear (flag_clear),
    .flag       (flag_b),
    .lockout    (lock_b)
  );
  oc_counter u_oc_hs ( // RULE6
    .ref_clk    (ref_clk),
    .srst_n     (srst_n),
    .tick       (cyc_a), // RULE26
    .oc_event   (hs_trip),
    .flag_clear (flag_clear),
    .flag       (flag_hs),
    .lockout    (lock_hs)
  );

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  // Command, strap, oscillator and load level
  always_ff @(posedge ref_clk) begin
    if (!srst_n) begin
      cmd_reg       <= CMD_RESET;
      osc_reg       <= 1'b0;
      blank_sel_reg <= 2'h0;
      load_reg      <= '0;
    end else begin
      if (cmd_valid) cmd_reg <= cmd_word;
      osc_reg       <= osc_in;
      blank_sel_reg <= {blank_select_high, blank_select_low};
      if (step_a | step_b) load_reg <= load_sample; // RULE1
    end
  end
  // Gate drive and status outputs
  always_ff @(posedge ref_clk) begin
    if (!srst_n) begin
      gates_a_reg <= GATE_OFF; // RULE11
      gates_b_reg <= GATE_OFF;
      status_reg  <= STATUS_RESET;
    end else begin
      gates_a_reg <= overtemp ? GATE_OFF : br_a.gates; // RULE10
      gates_b_reg <= overtemp ? GATE_OFF : br_b.gates; // RULE10
      status_reg  <= {load_reg, 1'b1, overtemp, prewarn, undervolt,
                      flag_hs, open_load_b & ~code_zero_b,
                      open_load_a & ~code_zero_a,
                      flag_b, flag_a}; // RULE22 RULE23
    end
  end
  // Low-current shutdown follows the disable pin
  always_ff @(posedge ref_clk) begin
    if (!rst_n) shutdown_reg <= 1'b0;
    else shutdown_reg <= disable_pin; // RULE11
  end
  assign gates_a     = gates_a_reg;
  assign gates_b     = gates_b_reg;
  assign shutdown    = shutdown_reg;
  assign status_word = status_reg;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  // Lockout length counted in cycle starts
  always_ff @(posedge ref_clk) begin
    if (!srst_n || !lock_a) lock_ticks <= '0;
    else if (cyc_a) lock_ticks <= lock_ticks + 1'b1;
  end

  property p_ls_off;
    @(posedge ref_clk) disable iff (!srst_n)
    (br_a.driving && lowside_comp_a && !br_a.blank_active &&
     !br_a.code_zero) |=> (br_a.state == CH_OFF) ##1 (gates_a == GATE_OFF);
  endproperty
  a_ls_off: assert property (p_ls_off) // RULE2
    else $error("low-side trip did not switch bridge A off");

  property p_lock_len;
    @(posedge ref_clk) disable iff (!srst_n)
    lock_a |-> (lock_ticks < OC_LOCK_CYCLES) && flag_a &&
      (br_a.code_zero || !br_a.driving);
  endproperty
  a_lock_len: assert property (p_lock_len) // RULE3
    else $error("bridge A lockout too long or bridge driving");

  property p_clear_early;
    @(posedge ref_clk) disable iff (!srst_n)
    (flag_clear && !br_a.oc_event && !br_b.oc_event && !hs_trip) |=>
      !lock_a && !lock_b && !lock_hs && !flag_a && !flag_b && !flag_hs;
  endproperty
  a_clear_early: assert property (p_clear_early) // RULE4
    else $error("zero frame did not end lockout and clear flags");

  property p_blank;
    @(posedge ref_clk) disable iff (!srst_n)
    (br_a.state == CH_ON && br_a.blank_active && !br_a.kill &&
     !br_a.code_zero) |=> br_a.state != CH_OFF;
  endproperty
  a_blank: assert property (p_blank) // RULE7
    else $error("bridge A tripped during blanking");

  property p_hs_off;
    @(posedge ref_clk) disable iff (!srst_n)
    hs_trip |=> !br_a.driving && !br_b.driving ##1
      (gates_a != GATE_ON_P0 && gates_a != GATE_ON_P1);
  endproperty
  a_hs_off: assert property (p_hs_off) // RULE8
    else $error("high-side trip left a bridge driving");

  property p_overtemp;
    @(posedge ref_clk) disable iff (!rst_n)
    overtemp |=> gates_a == GATE_OFF && gates_b == GATE_OFF;
  endproperty
  a_overtemp: assert property (p_overtemp) // RULE10
    else $error("gates on during overtemperature");

  property p_disable;
    @(posedge ref_clk) disable iff (!rst_n)
    disable_pin |=> gates_a == GATE_OFF && gates_b == GATE_OFF &&
      status_word == STATUS_RESET && shutdown;
  endproperty
  a_disable: assert property (p_disable) // RULE11
    else $error("disable did not clear outputs");

  property p_phase;
    @(posedge ref_clk) disable iff (!srst_n)
    cyc_a |-> !cyc_b ##1 !cyc_b && !cyc_a;
  endproperty
  a_phase: assert property (p_phase) // RULE12
    else $error("both bridges started together");

  property p_restart;
    @(posedge ref_clk) disable iff (!srst_n)
    ($changed(br_a.polarity) && !br_a.code_zero && !br_a.kill &&
     !br_a.oc_event) |=> br_a.state == CH_ON && br_a.blank_active;
  endproperty
  a_restart: assert property (p_restart) // RULE14
    else $error("polarity change did not restart bridge A");

  property p_fast;
    @(posedge ref_clk) disable iff (!srst_n)
    (br_a.state == CH_FAST && !overtemp && !$changed(br_a.polarity)) |=>
      gates_a == ($past(br_a.polarity) ? GATE_FAST_P1 : GATE_FAST_P0);
  endproperty
  a_fast: assert property (p_fast) // RULE15
    else $error("wrong fast decay pattern on bridge A");

  property p_slow;
    @(posedge ref_clk) disable iff (!srst_n)
    (br_b.state == CH_SLOW && !overtemp) |=> gates_b == GATE_SLOW;
  endproperty
  a_slow: assert property (p_slow) // RULE16
    else $error("wrong slow decay pattern on bridge B");

  property p_code_zero;
    @(posedge ref_clk) disable iff (!srst_n)
    (br_b.code_zero && !overtemp) ##1 !overtemp |->
      br_b.state == CH_IDLE ##1 gates_b == GATE_SLOW;
  endproperty
  a_code_zero: assert property (p_code_zero) // RULE24
    else $error("zero code did not hold bridge B in slow decay");

  property p_status;
    @(posedge ref_clk) disable iff (!srst_n)
    1'b1 |=> status_word[ST_OCA] == $past(flag_a) &&
      status_word[ST_OCB] == $past(flag_b) &&
      status_word[ST_HIGHSIDE_OVERCURRENT_FLAG] == $past(flag_hs) &&
      status_word[ST_OT] == $past(overtemp);
  endproperty
  a_status: assert property (p_status) // RULE23
    else $error("status flags do not follow the counters");

  property p_load;
    @(posedge ref_clk) disable iff (!srst_n)
    (step_a || step_b) |=> ##1
      status_word[LOAD_LEVEL_MSB:LOAD_LEVEL_LSB] == $past(load_sample, 2)
      && status_word[ST_ONE];
  endproperty
  a_load: assert property (p_load) // RULE1 RULE22
    else $error("load level not reported after a fullstep");

  property p_mixed;
    @(posedge ref_clk) disable iff (!srst_n)
    (br_a.state == CH_ON && !mixed_decay_on_a) |=> br_a.state != CH_FAST;
  endproperty
  a_mixed: assert property (p_mixed) // RULE25
    else $error("fast decay entered with mixed decay off");
endmodule
`default_nettype wire

// >>> tb/coil_model.sv
// Coil current and comparator model for the chopper bench
`timescale 1ns/1ps
`default_nettype none
module coil_model #(
  parameter int RISE = 40
) (
  input  wire logic       ref_clk,
  input  wire logic [3:0] gates_a,
  input  wire logic [3:0] gates_b,
  input  wire logic       fault_a,
  input  wire logic       fault_hs,
  output logic            lowside_comp_a,
  output logic            sense_comp_a,
  output logic            sense_comp_b,
  output logic            highside_comp
);
  int n_a = 0;
  int n_b = 0;
  // Current builds only while a high-side switch conducts
  always @(posedge ref_clk) begin
    n_a <= (|gates_a[3:2]) ? n_a + 1 : 0;
    n_b <= (|gates_b[3:2]) ? n_b + 1 : 0;
  end
  assign sense_comp_a = n_a >= RISE;
  assign sense_comp_b = n_b >= RISE;
  // Shorts show only while a coil is driven
  assign lowside_comp_a = fault_a & (|gates_a[3:2]);
  assign highside_comp = fault_hs & (|{gates_a[3:2], gates_b[3:2]});
endmodule
`default_nettype wire

// >>> tb/stepper_chopper_protection_tb_top.sv
// Self-checking bench for the stepper chopper and protection block
`timescale 1ns/1ps
`default_nettype none
module stepper_chopper_protection_tb_top;
  import stepper_pkg::*;
  logic ref_clk = 0, rst_n = 0, disable_pin = 0, osc = 0, cv = 0, ot = 0;
  logic fa = 0, fh = 0, lsa, sca, scb, hsc, sd;
  logic pw = 0, uv = 0;
  logic [1:0] bs = 2'h0;
  logic [2:0] ld = 3'h5;
  logic [11:0] cmd = 12'h000, st;
  logic [3:0] ga, gb;
  int err_total = 0, n_compared = 0, k = 0;
  // Clock and a PWM oscillator of 300 cycles
  always #12.5 ref_clk = ~ref_clk;
  always @(negedge ref_clk) begin
    k <= k + 1;
    if (k % 150 == 149)
      osc <= ~osc;
  end
  stepper_chopper_protection #(.FAST_MAX(60)) stepper_chopper_protection_i (
    .ref_clk(ref_clk), .rst_n(rst_n), .disable_pin(disable_pin),
    .osc_in(osc), .cmd_word(cmd), .cmd_valid(cv),
    .blank_select_low(bs[0]), .blank_select_high(bs[1]),
    .lowside_comp_a(lsa), .lowside_comp_b(1'b0), .sense_comp_a(sca),
    .sense_comp_b(scb), .highside_comp(hsc), .overtemp(ot),
    .prewarn(pw), .undervolt(uv), .open_load_a(1'b0),
    .open_load_b(1'b0), .load_sample(ld), .gates_a(ga), .gates_b(gb),
    .shutdown(sd), .status_word(st));
  coil_model coil_model_i (.ref_clk(ref_clk), .gates_a(ga), .gates_b(gb),
    .fault_a(fa), .fault_hs(fh), .lowside_comp_a(lsa),
    .sense_comp_a(sca), .sense_comp_b(scb), .highside_comp(hsc));
  task automatic chk(string nm, logic [11:0] e, logic [11:0] g);
    n_compared++;
    if (g !== e) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic send(logic [11:0] w);
    @(negedge ref_clk);
    cmd = w;
    cv = 1;
    @(negedge ref_clk);
    cv = 0;
  endtask
  // Wait n cycles after an oscillator rise (b=0) or fall (b=1)
  task automatic at(bit b, int n);
    if (b)
      @(negedge osc);
    else
      @(posedge osc);
    repeat (n) @(negedge ref_clk);
  endtask
  task automatic summarize;
    $display("compared %0d errors %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // Watchdog
  initial begin
    repeat (30000) @(posedge ref_clk);
    err_total++;
    summarize();
  end
  // --------------------------------
  // Test sequence
  // --------------------------------
  initial begin
    repeat (8) @(negedge ref_clk);
    rst_n = 1;
    repeat (3) @(negedge ref_clk);
    chk("gates_a", 12'h3, 12'(ga));
    chk("status", 12'h100, st);
    for (int i = 0; i < 4; i++) begin
      send({i[1], 4'hf, i[0], i[1], 4'hf, i[0]});
      at(1, 10);
      chk("gates_b on", i[0] ? 12'h6 : 12'h9, 12'(gb));
      at(0, 10);
      chk("gates_a on", i[0] ? 12'h6 : 12'h9, 12'(ga));
      chk("gates_b off phase", 12'h3, 12'(gb));
      repeat (40) @(negedge ref_clk);
      chk("decay", i[1] ? (i[0] ? 12'h1 : 12'h2) : 12'h3, 12'(ga));
      repeat (50) @(negedge ref_clk);
      chk("slow", 12'h3, 12'(ga));
    end
    chk("load", 12'h5, 12'(st[11:9]));
    for (int b = 0; b < 2; b++) begin
      send(12'h780);
      repeat (60) @(negedge ref_clk);
      {fh, fa} = b ? 2'b10 : 2'b01;
      bs = 2'(b);
      for (int i = 0; i < 3; i++) begin
        at(0, b ? 30 : 10);
        chk("blanked", 12'h9, 12'(ga));
        repeat (b ? 20 : 40) @(negedge ref_clk);
        chk("tripped", 12'h0, 12'(ga));
      end
      {fh, fa} = 2'b00;
      chk("flag", 12'h1, 12'(st[b ? 4 : 0]));
      at(0, 10);
      chk("lockout", 12'h0, 12'(ga));
      send(12'h000);
      repeat (3) @(negedge ref_clk);
      chk("flags", 12'h0, st & 12'h013);
    end
    send(12'h780);
    {ot, pw, uv} = 3'h7;
    repeat (3) @(negedge ref_clk);
    chk("ot gates", 12'h0, {4'h0, ga, gb});
    chk("ot flags", 12'h7, 12'(st[7:5]));
    {ot, pw, uv} = 3'h0;
    at(0, 10);
    chk("resume", 12'h9, 12'(ga));
    disable_pin = 1;
    repeat (3) @(negedge ref_clk);
    chk("shutdown", 12'h1, 12'(sd));
    chk("status", 12'h100, st);
    chk("gates", 12'h0, {4'h0, ga, gb});
    summarize();
  end
endmodule
`default_nettype wire
